// [imsc_pkg.sv]
/*
 * Constants for the clock set-up and strobe register bank: offsets,
 * field widths and reset values. Assumes 16-bit register indices and
 * 8-bit register data on the serial control port's internal side.
 */
package imsc_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [15:0] OFS_VT_PIX_DIV   = 16'h0301;
	localparam logic [15:0] OFS_VT_SYS_DIV   = 16'h0303;
	localparam logic [15:0] OFS_VT_PRE_DIV   = 16'h0304;
	localparam logic [15:0] OFS_OUT_PRE_DIV  = 16'h0305;
	localparam logic [15:0] OFS_VT_MPY_HI    = 16'h0306;
	localparam logic [15:0] OFS_VT_MPY_LO    = 16'h0307;
	localparam logic [15:0] OFS_OUT_PIX_DIV  = 16'h0309;
	localparam logic [15:0] OFS_OUT_SYS_DIV  = 16'h030b;
	localparam logic [15:0] OFS_OUT_MPY_HI   = 16'h030c;
	localparam logic [15:0] OFS_OUT_MPY_LO   = 16'h030d;
	localparam logic [15:0] OFS_STB_TRIG     = 16'h0320;
	localparam logic [15:0] OFS_STB_STATE    = 16'h0321;
	localparam logic [15:0] OFS_STB_TDIV     = 16'h0322;
	localparam logic [15:0] OFS_STB_PIN_EN   = 16'h0324;
	localparam logic [15:0] OFS_STB_MODE     = 16'h032e;
	localparam logic [15:0] OFS_STB_REF      = 16'h032f;
	localparam logic [15:0] OFS_STB_START_HI = 16'h0330;
	localparam logic [15:0] OFS_STB_START_LO = 16'h0331;
	localparam logic [15:0] OFS_STB_LAT_HI   = 16'h0332;
	localparam logic [15:0] OFS_STB_LAT_LO   = 16'h0333;
	localparam logic [15:0] OFS_STB_HIGH_HI  = 16'h0334;
	localparam logic [15:0] OFS_STB_HIGH_LO  = 16'h0335;
	localparam logic [15:0] OFS_STB_LOW_HI   = 16'h0336;
	localparam logic [15:0] OFS_STB_LOW_LO   = 16'h0337;
	localparam logic [15:0] OFS_STB_COUNT    = 16'h0338;
	localparam logic [15:0] OFS_H_EVEN_STEP  = 16'h0381;
	localparam logic [15:0] OFS_V_EVEN_STEP  = 16'h0383;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [4:0]  RST_PIX_VT  = 5'h05;
	localparam logic [1:0]  RST_SYS_DIV = 2'h1;
	localparam logic [7:0]  RST_PRE_DIV = 8'h02;
	localparam logic [10:0] RST_MPY     = 11'h075;
	localparam logic [4:0]  RST_PIX_OUT = 5'h0a;
	localparam logic [7:0]  RST_TDIV    = 8'h01;
	localparam logic [15:0] RST_PERIOD  = 16'h0001;
	localparam logic [7:0]  RST_COUNT   = 8'h01;
	localparam logic [2:0]  EVEN_STEP   = 3'h1;
	localparam logic [7:0]  RD_UNMAPPED = 8'h00;
	// ----------------------------------------
	// Strobe modes and sequencer states
	// ----------------------------------------
	localparam logic [1:0] MODE_SHUT_ONE  = 2'h0;
	localparam logic [1:0] MODE_SHUT_CONT = 2'h1;
	localparam logic [1:0] MODE_VCNT_ONE  = 2'h2;
	localparam int PIN_EN_ROLLING = 0;
	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_ARMED = 5'b00010,
		ST_DELAY = 5'b00100,
		ST_HIGH  = 5'b01000,
		ST_LOW   = 5'b10000
	} imsc_stb_e;
endpackage : imsc_pkg

// [imsc_tick_div.sv]
/*
 * Tick divider: one-cycle enable every divide cycles.
 * Assumes divide is stable while in use; zero acts as one.
 */
`timescale 1ns/1ps
`default_nettype none
module imsc_tick_div #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             rstn,
	// Control
	input  wire logic [WIDTH-1:0] divide,
	// Enable pulse
	output logic                  tick
);
	logic [WIDTH-1:0] cnt_r;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= '0;
		end else if (cnt_r + WIDTH'(1) >= divide) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + WIDTH'(1);
		end
	end

	// Shrinking divide mid-count ends the period at once
	assign tick = (cnt_r + WIDTH'(1) >= divide);
endmodule : imsc_tick_div
`default_nettype wire

// [imsc_setup_regs.sv]
/*
 * Clock set-up and strobe register bank of the sensor, with the
 * strobe sequencer. Assumes the serial control port decodes into
 * one-cycle byte writes and a combinational byte read, and that
 * frame and exposure events are one-cycle pulses on core_clk.
 */
// How it works
// - 5-bit video pixel divider, writable, resets to 05.
// - 2-bit video system divider, writable, resets to 1.
// - Output pre-divider same choice; resets to 2, applied at vsync.
// - 11-bit video multiplier over two bytes, resets 75, applied at vsync.
// - 5-bit output pixel divider, writable, resets to 0A.
// - 2-bit output system divider, writable, resets to 1.
// - 11-bit output multiplier over two bytes, resets 75, applied at vsync.
// - One writable bit, reset 0, triggers the strobe sequence.
// - Strobe events timed by programmable 8-bit divider, reset 01.
// - Strobe pin driven only when enable bit 0 set; bit 1 reserved.
// - Mode 0 single shutter, 1 continuous shutter, 2 single vertical count.
// - Reference bit picks exposure start (0) or read-out start (1).
// - 16-bit start point over two bytes, reset zero, offsets from reference.
// - 16-bit latency, reset zero, further delays strobe assertion.
// - 16-bit high period, reset 0001, length of each pulse.
// - 16-bit low period, reset 0001, gap between pulses.
// - 8-bit pulse count, reset 01, pulses per sequence.
// - Even step registers are 3-bit read-only, always reading 1.
`timescale 1ns/1ps
`default_nettype none
module imsc_setup_regs
	import imsc_pkg::*;
#(
	parameter int TDIV_W = 8,
	parameter int TIME_W = 16,
	parameter int CNT_W  = 8
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rstn,
	// Register access port
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic              regWrEn,
	input  wire logic [DATA_W-1:0] regWrData,
	output logic      [DATA_W-1:0] regRdData,
	// Frame timing events
	input  wire logic              vsyncPulse,
	input  wire logic              exposureStart,
	input  wire logic              readoutStart,
	input  wire logic              vcntSyncPulse,
	// Video timing clock configuration
	output logic      [4:0]        vtPixelDivider,
	output logic      [1:0]        vtSystemDivider,
	output logic      [7:0]        vtPrepllDivider,
	output logic      [10:0]       vtMultiplier,
	// Output path clock configuration
	output logic      [4:0]        outPixelDivider,
	output logic      [1:0]        outSystemDivider,
	output logic      [7:0]        outPrepllDivider,
	output logic      [10:0]       outMultiplier,
	// Strobe pin
	output logic                   strobePinOut,
	output logic                   strobePinOe
);
	// ----------------------------------------
	// Decode
	// ----------------------------------------
	function automatic logic wrHit(
		input logic [ADDR_W-1:0] ofs
	);
		wrHit = regWrEn && (regAddr == ofs);
	endfunction : wrHit

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [7:0]        vtPreShadow_r;
	logic [7:0]        outPreShadow_r;
	logic [10:0]       vtMpyShadow_r;
	logic [10:0]       outMpyShadow_r;
	logic              trigger_r;
	logic [TDIV_W-1:0] tickDiv_r;
	logic [1:0]        pinEnable_r;
	logic [1:0]        mode_r;
	logic              refSel_r;
	logic [TIME_W-1:0] startPoint_r;
	logic [TIME_W-1:0] latency_r;
	logic [TIME_W-1:0] highTime_r;
	logic [TIME_W-1:0] lowTime_r;
	logic [CNT_W-1:0]  pulseCount_r;
	imsc_stb_e         state_r;
	logic [TIME_W:0]   phaseCnt_r;
	logic [CNT_W-1:0]  pulsesLeft_r;
	logic              strobe_r;
	logic              tick;
	logic              refEvent;
	logic              busy;
	logic              seqDone;
	logic              phaseEnd;

	// ----------------------------------------
	// Immediate dividers
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			vtPixelDivider <= RST_PIX_VT;
		end else if (wrHit(OFS_VT_PIX_DIV)) begin
			vtPixelDivider <= regWrData[4:0];
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			vtSystemDivider <= RST_SYS_DIV;
		end else if (wrHit(OFS_VT_SYS_DIV)) begin
			vtSystemDivider <= regWrData[1:0];
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			outPixelDivider <= RST_PIX_OUT;
		end else if (wrHit(OFS_OUT_PIX_DIV)) begin
			outPixelDivider <= regWrData[4:0];
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			outSystemDivider <= RST_SYS_DIV;
		end else if (wrHit(OFS_OUT_SYS_DIV)) begin
			outSystemDivider <= regWrData[1:0];
		end
	end

	// ----------------------------------------
	// Frame-timed shadows
	// ----------------------------------------
	// Value range is the host's to respect; any byte is stored
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			vtPreShadow_r  <= RST_PRE_DIV;
			outPreShadow_r <= RST_PRE_DIV;
		end else begin
			if (wrHit(OFS_VT_PRE_DIV)) begin
				vtPreShadow_r <= regWrData;
			end
			if (wrHit(OFS_OUT_PRE_DIV)) begin
				outPreShadow_r <= regWrData;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			vtMpyShadow_r  <= RST_MPY;
			outMpyShadow_r <= RST_MPY;
		end else begin
			if (wrHit(OFS_VT_MPY_HI)) begin
				vtMpyShadow_r[10:8] <= regWrData[2:0];
			end
			if (wrHit(OFS_VT_MPY_LO)) begin
				vtMpyShadow_r[7:0] <= regWrData;
			end
			if (wrHit(OFS_OUT_MPY_HI)) begin
				outMpyShadow_r[10:8] <= regWrData[2:0];
			end
			if (wrHit(OFS_OUT_MPY_LO)) begin
				outMpyShadow_r[7:0] <= regWrData;
			end
		end
	end

	// Copying both bytes together keeps a split multiplier write atomic
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			vtPrepllDivider  <= RST_PRE_DIV;
			outPrepllDivider <= RST_PRE_DIV;
			vtMultiplier     <= RST_MPY;
			outMultiplier    <= RST_MPY;
		end else if (vsyncPulse) begin
			vtPrepllDivider  <= vtPreShadow_r;
			outPrepllDivider <= outPreShadow_r;
			vtMultiplier     <= vtMpyShadow_r;
			outMultiplier    <= outMpyShadow_r;
		end
	end

	// ----------------------------------------
	// Strobe settings
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tickDiv_r   <= RST_TDIV;
			pinEnable_r <= '0;
			mode_r      <= MODE_SHUT_ONE;
			refSel_r    <= 1'b0;
		end else begin
			if (wrHit(OFS_STB_TDIV)) begin
				tickDiv_r <= regWrData;
			end
			if (wrHit(OFS_STB_PIN_EN)) begin
				pinEnable_r <= regWrData[1:0];
			end
			if (wrHit(OFS_STB_MODE)) begin
				mode_r <= regWrData[1:0];
			end
			if (wrHit(OFS_STB_REF)) begin
				refSel_r <= regWrData[0];
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			startPoint_r <= '0;
			latency_r    <= '0;
		end else begin
			if (wrHit(OFS_STB_START_HI)) begin
				startPoint_r[15:8] <= regWrData;
			end
			if (wrHit(OFS_STB_START_LO)) begin
				startPoint_r[7:0] <= regWrData;
			end
			if (wrHit(OFS_STB_LAT_HI)) begin
				latency_r[15:8] <= regWrData;
			end
			if (wrHit(OFS_STB_LAT_LO)) begin
				latency_r[7:0] <= regWrData;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			highTime_r   <= RST_PERIOD;
			lowTime_r    <= RST_PERIOD;
			pulseCount_r <= RST_COUNT;
		end else begin
			if (wrHit(OFS_STB_HIGH_HI)) begin
				highTime_r[15:8] <= regWrData;
			end
			if (wrHit(OFS_STB_HIGH_LO)) begin
				highTime_r[7:0] <= regWrData;
			end
			if (wrHit(OFS_STB_LOW_HI)) begin
				lowTime_r[15:8] <= regWrData;
			end
			if (wrHit(OFS_STB_LOW_LO)) begin
				lowTime_r[7:0] <= regWrData;
			end
			if (wrHit(OFS_STB_COUNT)) begin
				pulseCount_r <= regWrData;
			end
		end
	end

	// Single modes clear the trigger on completion; a write wins
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			trigger_r <= 1'b0;
		end else if (wrHit(OFS_STB_TRIG)) begin
			trigger_r <= regWrData[0];
		end else if (seqDone && mode_r != MODE_SHUT_CONT) begin
			trigger_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Strobe sequencer
	// ----------------------------------------
	imsc_tick_div #(
		.WIDTH (TDIV_W)
	) u_tick (
		.core_clk (core_clk),
		.rstn     (rstn),
		.divide   (tickDiv_r),
		.tick     (tick)
	);

	assign refEvent = (mode_r == MODE_VCNT_ONE) ? vcntSyncPulse
		: (refSel_r ? readoutStart : exposureStart);
	// A zero period still lasts one tick
	assign phaseEnd = tick && (phaseCnt_r <= (TIME_W + 1)'(1));
	// A zero pulse count ends the sequence with the delay
	assign seqDone  = phaseEnd && ((state_r == ST_HIGH && pulsesLeft_r <= CNT_W'(1))
		|| (state_r == ST_DELAY && pulsesLeft_r == '0));
	assign busy     = (state_r == ST_DELAY) || (state_r == ST_HIGH)
		|| (state_r == ST_LOW);

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_r      <= ST_IDLE;
			phaseCnt_r   <= '0;
			pulsesLeft_r <= '0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (trigger_r) begin
						state_r <= ST_ARMED;
					end
				end
				ST_ARMED: begin
					if (!trigger_r) begin
						state_r <= ST_IDLE;
					end else if (refEvent) begin
						state_r      <= ST_DELAY;
						phaseCnt_r   <= startPoint_r + latency_r;
						pulsesLeft_r <= pulseCount_r;
					end
				end
				ST_DELAY: begin
					if (phaseEnd) begin
						if (pulsesLeft_r == '0) begin
							state_r <= ST_IDLE;
						end else begin
							state_r    <= ST_HIGH;
							phaseCnt_r <= {1'b0, highTime_r};
						end
					end else if (tick) begin
						phaseCnt_r <= phaseCnt_r - (TIME_W + 1)'(1);
					end
				end
				ST_HIGH: begin
					if (seqDone) begin
						// Continuous mode rearms for the next reference
						state_r <= (mode_r == MODE_SHUT_CONT && trigger_r)
							? ST_ARMED : ST_IDLE;
					end else if (phaseEnd) begin
						state_r      <= ST_LOW;
						phaseCnt_r   <= {1'b0, lowTime_r};
						pulsesLeft_r <= pulsesLeft_r - CNT_W'(1);
					end else if (tick) begin
						phaseCnt_r <= phaseCnt_r - (TIME_W + 1)'(1);
					end
				end
				ST_LOW: begin
					if (phaseEnd) begin
						state_r    <= ST_HIGH;
						phaseCnt_r <= {1'b0, highTime_r};
					end else if (tick) begin
						phaseCnt_r <= phaseCnt_r - (TIME_W + 1)'(1);
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Registered so the pin never glitches on a state change
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			strobe_r <= 1'b0;
		end else begin
			strobe_r <= (state_r == ST_HIGH);
		end
	end

	assign strobePinOe  = pinEnable_r[PIN_EN_ROLLING];
	assign strobePinOut = strobe_r && pinEnable_r[PIN_EN_ROLLING];

	// ----------------------------------------
	// Read back
	// ----------------------------------------
	always_comb begin
		case (regAddr)
			OFS_VT_PIX_DIV:   regRdData = {3'h0, vtPixelDivider};
			OFS_VT_SYS_DIV:   regRdData = {6'h00, vtSystemDivider};
			OFS_VT_PRE_DIV:   regRdData = vtPreShadow_r;
			OFS_OUT_PRE_DIV:  regRdData = outPreShadow_r;
			OFS_VT_MPY_HI:    regRdData = {5'h00, vtMpyShadow_r[10:8]};
			OFS_VT_MPY_LO:    regRdData = vtMpyShadow_r[7:0];
			OFS_OUT_PIX_DIV:  regRdData = {3'h0, outPixelDivider};
			OFS_OUT_SYS_DIV:  regRdData = {6'h00, outSystemDivider};
			OFS_OUT_MPY_HI:   regRdData = {5'h00, outMpyShadow_r[10:8]};
			OFS_OUT_MPY_LO:   regRdData = outMpyShadow_r[7:0];
			OFS_STB_TRIG:     regRdData = {7'h00, trigger_r};
			OFS_STB_STATE:    regRdData = {7'h00, busy};
			OFS_STB_TDIV:     regRdData = tickDiv_r;
			OFS_STB_PIN_EN:   regRdData = {6'h00, pinEnable_r};
			OFS_STB_MODE:     regRdData = {6'h00, mode_r};
			OFS_STB_REF:      regRdData = {7'h00, refSel_r};
			OFS_STB_START_HI: regRdData = startPoint_r[15:8];
			OFS_STB_START_LO: regRdData = startPoint_r[7:0];
			OFS_STB_LAT_HI:   regRdData = latency_r[15:8];
			OFS_STB_LAT_LO:   regRdData = latency_r[7:0];
			OFS_STB_HIGH_HI:  regRdData = highTime_r[15:8];
			OFS_STB_HIGH_LO:  regRdData = highTime_r[7:0];
			OFS_STB_LOW_HI:   regRdData = lowTime_r[15:8];
			OFS_STB_LOW_LO:   regRdData = lowTime_r[7:0];
			OFS_STB_COUNT:    regRdData = pulseCount_r;
			OFS_H_EVEN_STEP:  regRdData = {5'h00, EVEN_STEP};
			OFS_V_EVEN_STEP:  regRdData = {5'h00, EVEN_STEP};
			default:          regRdData = RD_UNMAPPED;
		endcase
	end
endmodule : imsc_setup_regs
`default_nettype wire

// [imsc_setup_regs_assertions.sv]
/*
 * Checker for the set-up register bank: write paths, frame-boundary
 * holding, strobe pin gating and fixed read values.
 * Assumes it is bound to imsc_setup_regs and sees its ports only.
 */
`timescale 1ns/1ps
`default_nettype none
module imsc_setup_regs_assertions
	import imsc_pkg::*;
(
	// Clock and reset
	input wire logic              core_clk,
	input wire logic              rstn,
	// Register access port
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic              regWrEn,
	input wire logic [DATA_W-1:0] regWrData,
	input wire logic [DATA_W-1:0] regRdData,
	// Frame and clock configuration
	input wire logic              vsyncPulse,
	input wire logic [4:0]        vtPixelDivider,
	input wire logic [1:0]        vtSystemDivider,
	input wire logic [7:0]        vtPrepllDivider,
	input wire logic [10:0]       vtMultiplier,
	input wire logic [4:0]        outPixelDivider,
	input wire logic [1:0]        outSystemDivider,
	input wire logic [7:0]        outPrepllDivider,
	input wire logic [10:0]       outMultiplier,
	// Strobe pin
	input wire logic              strobePinOut,
	input wire logic              strobePinOe
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	sequence s_wr_at(logic [15:0] a);
		regWrEn && regAddr == a;
	endsequence
	sequence s_rd_after_wr(logic [15:0] a);
		s_wr_at(a) ##1 (!regWrEn && regAddr == a);
	endsequence
	property p_vt_pix;
		s_wr_at(OFS_VT_PIX_DIV) |=> vtPixelDivider == $past(regWrData[4:0]);
	endproperty
	a_vt_pix: assert property (p_vt_pix) else $error("vt pixel divider missed write");
	property p_vt_sys;
		s_wr_at(OFS_VT_SYS_DIV) |=> vtSystemDivider == $past(regWrData[1:0]);
	endproperty
	a_vt_sys: assert property (p_vt_sys) else $error("vt system divider missed write");
	property p_out_pix;
		s_wr_at(OFS_OUT_PIX_DIV) |=> outPixelDivider == $past(regWrData[4:0]);
	endproperty
	a_out_pix: assert property (p_out_pix) else $error("out pixel divider missed write");
	property p_out_sys;
		s_wr_at(OFS_OUT_SYS_DIV) |=> outSystemDivider == $past(regWrData[1:0]);
	endproperty
	a_out_sys: assert property (p_out_sys) else $error("out system divider missed write");
	// Frame-timed settings may only move on a frame boundary
	property p_vt_hold;
		!vsyncPulse |=> $stable(vtMultiplier) && $stable(vtPrepllDivider);
	endproperty
	a_vt_hold: assert property (p_vt_hold) else $error("vt pll setting moved");
	property p_out_hold;
		!vsyncPulse |=> $stable(outMultiplier) && $stable(outPrepllDivider);
	endproperty
	a_out_hold: assert property (p_out_hold) else $error("out pll setting moved");
	property p_pin_gate;
		!strobePinOe |-> !strobePinOut;
	endproperty
	a_pin_gate: assert property (p_pin_gate) else $error("strobe driven while disabled");
	property p_oe_src;
		$rose(strobePinOe) |-> $past(regWrEn && regAddr == OFS_STB_PIN_EN && regWrData[0]);
	endproperty
	a_oe_src: assert property (p_oe_src) else $error("pin enable rose unbidden");
	property p_even;
		(regAddr == OFS_H_EVEN_STEP || regAddr == OFS_V_EVEN_STEP) |-> regRdData == 8'h01;
	endproperty
	a_even: assert property (p_even) else $error("even step read wrong");
	property p_tdiv_rb;
		s_rd_after_wr(OFS_STB_TDIV) |-> regRdData == $past(regWrData);
	endproperty
	a_tdiv_rb: assert property (p_tdiv_rb) else $error("tick divider readback wrong");
endmodule : imsc_setup_regs_assertions
bind imsc_setup_regs imsc_setup_regs_assertions chk_u (
	.core_clk(core_clk), .rstn(rstn), .regAddr(regAddr), .regWrEn(regWrEn),
	.regWrData(regWrData), .regRdData(regRdData), .vsyncPulse(vsyncPulse),
	.vtPixelDivider(vtPixelDivider), .vtSystemDivider(vtSystemDivider),
	.vtPrepllDivider(vtPrepllDivider), .vtMultiplier(vtMultiplier),
	.outPixelDivider(outPixelDivider), .outSystemDivider(outSystemDivider),
	.outPrepllDivider(outPrepllDivider), .outMultiplier(outMultiplier),
	.strobePinOut(strobePinOut), .strobePinOe(strobePinOe)
);
`default_nettype wire

// [imsc_flash_model.sv]
/*
 * Far-side model: frame timing source and flash driver input.
 * Assumes one clock; statClr clears the pulse statistics.
 */
`timescale 1ns/1ps
`default_nettype none
module imsc_flash_model (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rstn,
	// Bench control
	input  wire logic        frameRun,
	input  wire logic        statClr,
	// Strobe pin
	input  wire logic        strobePinOut,
	input  wire logic        strobePinOe,
	// Frame events
	output logic             vsyncPulse,
	output logic             exposureStart,
	output logic             readoutStart,
	output logic             vcntSyncPulse,
	// Measurements
	output logic [7:0]       pulseCnt,
	output logic [15:0]      hiMin,
	output logic [15:0]      hiMax,
	output logic [15:0]      loMin,
	output logic [6:0]       firstRise
);
	logic [6:0]  framePos;
	logic        pinLine;
	logic        lineQ;
	logic        seen;
	logic [15:0] runLen;
	// Pull-down on the flash input, so an undriven pin reads low
	assign pinLine = strobePinOe & strobePinOut;
	// Fixed 128-cycle frame; references spaced 16 apart to tell them apart
	assign exposureStart = frameRun && framePos == 7'h04;
	assign readoutStart  = frameRun && framePos == 7'h14;
	assign vcntSyncPulse = frameRun && framePos == 7'h24;
	assign vsyncPulse    = frameRun && framePos == 7'h78;
	always @(posedge core_clk) begin
		framePos <= (!rstn || !frameRun) ? 7'h00 : framePos + 7'h01;
		lineQ <= pinLine;
		runLen <= (pinLine != lineQ) ? 16'h0001 : runLen + 16'h0001;
		if (!rstn || statClr) begin
			pulseCnt <= 8'h00;
			hiMin <= 16'hffff;
			hiMax <= 16'h0000;
			loMin <= 16'hffff;
			seen <= 1'b0;
			firstRise <= 7'h00;
		end else if (pinLine && !lineQ) begin
			pulseCnt <= pulseCnt + 8'h01;
			seen <= 1'b1;
			if (!seen) firstRise <= framePos;
			if (pulseCnt != 8'h00 && runLen < loMin) loMin <= runLen;
		end else if (!pinLine && lineQ) begin
			if (runLen < hiMin) hiMin <= runLen;
			if (runLen > hiMax) hiMax <= runLen;
		end
	end
endmodule : imsc_flash_model
`default_nettype wire

// [sensor_clock_and_strobe_setup_test.sv]
/*
 * Self-checking bench for the set-up register bank and strobe sequencer.
 * Assumes imsc_setup_regs, its checker and imsc_flash_model are compiled.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
	$display("mismatch %s exp %0h got %0h", n, e, g); end end
module sensor_clock_and_strobe_setup_test
	import imsc_pkg::*;
;
	logic core_clk = 1'b0, rstn = 1'b0, regWrEn = 1'b0, frameRun = 1'b0, statClr = 1'b0;
	logic [15:0] regAddr = 16'h0000, hiMin, hiMax, loMin;
	logic [7:0]  regWrData = 8'h00, regRdData, pulseCnt, wv [25];
	logic        vsyncPulse, exposureStart, readoutStart, vcntSyncPulse, pinOut, pinOe;
	logic [4:0]  vtPix, outPix;
	logic [1:0]  vtSys, outSys;
	logic [7:0]  vtPre, outPre;
	logic [10:0] vtMpy, outMpy;
	logic [6:0]  firstRise;
	int err_count = 0, cmp_count = 0, cyc = 0;
	// Offset, reset read value and writable mask; RO and unmapped at 21-24, reset-only writable ones last
	logic [15:0] ofs [28] = '{16'h0301, 16'h0303, 16'h0304, 16'h0305, 16'h0306, 16'h0307,
		16'h0309, 16'h030b, 16'h030c, 16'h030d, 16'h0322, 16'h032f, 16'h0330, 16'h0331,
		16'h0332, 16'h0333, 16'h0334, 16'h0335, 16'h0336, 16'h0337, 16'h0338, 16'h0321,
		16'h0381, 16'h0383, 16'h0300, 16'h0320, 16'h0324, 16'h032e};
	logic [7:0] rst [28] = '{8'h05, 8'h01, 8'h02, 8'h02, 8'h00, 8'h75, 8'h0a, 8'h01, 8'h00,
		8'h75, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h01,
		8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] msk [25] = '{8'h1f, 8'h03, 8'hff, 8'hff, 8'h07, 8'hff, 8'h1f, 8'h03, 8'h07,
		8'hff, 8'hff, 8'h01, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
		8'h00, 8'h00, 8'h00, 8'h00};
	// Strobe cases: mode, reference, enable, pulse count
	logic [11:0] cs [6] = '{{2'h0, 1'b0, 1'b1, 8'h02}, {2'h0, 1'b1, 1'b1, 8'h01},
		{2'h1, 1'b0, 1'b1, 8'h02}, {2'h2, 1'b0, 1'b1, 8'h03}, {2'h0, 1'b0, 1'b0, 8'h02},
		{2'h0, 1'b0, 1'b1, 8'h00}};

	imsc_setup_regs dut_u (.core_clk(core_clk), .rstn(rstn), .regAddr(regAddr),
		.regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData),
		.vsyncPulse(vsyncPulse), .exposureStart(exposureStart), .readoutStart(readoutStart),
		.vcntSyncPulse(vcntSyncPulse), .vtPixelDivider(vtPix), .vtSystemDivider(vtSys),
		.vtPrepllDivider(vtPre), .vtMultiplier(vtMpy), .outPixelDivider(outPix),
		.outSystemDivider(outSys), .outPrepllDivider(outPre), .outMultiplier(outMpy),
		.strobePinOut(pinOut), .strobePinOe(pinOe));
	imsc_flash_model frame_u (.core_clk(core_clk), .rstn(rstn), .frameRun(frameRun),
		.statClr(statClr), .strobePinOut(pinOut), .strobePinOe(pinOe),
		.vsyncPulse(vsyncPulse), .exposureStart(exposureStart), .readoutStart(readoutStart),
		.vcntSyncPulse(vcntSyncPulse), .pulseCnt(pulseCnt), .hiMin(hiMin), .hiMax(hiMax),
		.loMin(loMin), .firstRise(firstRise));

	always #4 core_clk = ~core_clk;
	// Hang guard, far above a full run
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 10000) begin
			err_count++;
			end_sim();
		end
	end
	// ----------------------------------------
	// Bus tasks and expectations
	// ----------------------------------------
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(posedge core_clk);
		#1 regWrEn = 1'b0;
		@(posedge core_clk) #1;
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		regAddr = a;
		#1 d = regRdData;
		@(posedge core_clk);
		#1;
	endtask : rd
	function automatic bit in_win(input logic [1:0] md, input logic rf, input int dl, dv,
		input logic [6:0] fr);
		int rp;
		rp = (md == 2'h2) ? 36 : (rf ? 20 : 4);
		return int'(fr) >= rp + 2 + (dl - 1) * dv && int'(fr) <= rp + 4 + dl * dv;
	endfunction : in_win
	task automatic strobe_run(input logic [11:0] c);
		logic [7:0] dv, hi, lo, st, lt, d, cnt;
		logic [1:0] md;
		logic rf, en;
		int n;
		{md, rf, en, cnt} = c;
		dv = 8'($urandom_range(1, 3));
		hi = 8'($urandom_range(1, 3));
		lo = 8'($urandom_range(1, 3));
		st = 8'($urandom_range(0, 2));
		lt = 8'($urandom_range(0, 2));
		wr(OFS_STB_TDIV, dv);
		wr(OFS_STB_START_HI, 8'h00);
		wr(OFS_STB_START_LO, st);
		wr(OFS_STB_LAT_HI, 8'h00);
		wr(OFS_STB_LAT_LO, lt);
		wr(OFS_STB_HIGH_HI, 8'h00);
		wr(OFS_STB_HIGH_LO, hi);
		wr(OFS_STB_LOW_HI, 8'h00);
		wr(OFS_STB_LOW_LO, lo);
		wr(OFS_STB_COUNT, cnt);
		wr(OFS_STB_MODE, {6'h00, md});
		wr(OFS_STB_REF, {7'h00, rf});
		wr(OFS_STB_PIN_EN, {6'h00, ~en, en});
		statClr = 1'b1;
		wr(OFS_STB_TRIG, 8'h01);
		statClr = 1'b0;
		frameRun = 1'b1;
		n = 0;
		do rd(OFS_STB_STATE, d); while (d !== 8'h01 && ++n < 200);
		`CHK("busy", 8'h01, d)
		repeat (340 - n) @(posedge core_clk);
		#1 frameRun = 1'b0;
		n = 0;
		do rd(OFS_STB_STATE, d); while (d !== 8'h00 && ++n < 300);
		`CHK("idle", 8'h00, d)
		rd(OFS_STB_TRIG, d);
		`CHK("trigger", {7'h00, md == 2'h1}, d)
		if (md == 2'h1) wr(OFS_STB_TRIG, 8'h00);
		`CHK("pulses", en ? cnt * (md == 2'h1 ? 8'h03 : 8'h01) : 8'h00, pulseCnt)
		if (en && cnt != 8'h00) begin
			`CHK("high", hi * dv, hiMax)
			`CHK("highmin", hi * dv, hiMin)
			`CHK("start", 1'b1, in_win(md, rf, (st + lt) > 0 ? st + lt : 1, dv, firstRise))
		end
		if (en && cnt > 8'h01) `CHK("low", lo * dv, loMin)
	endtask : strobe_run
	task automatic end_sim();
		$display("errors %0d comparisons %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_sim
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [7:0] d;
		void'($urandom(1));
		repeat (20) @(posedge core_clk);
		#1 rstn = 1'b1;
		for (int i = 0; i < 28; i++) begin
			rd(ofs[i], d);
			`CHK("reset", rst[i], d)
		end
		for (int i = 0; i < 25; i++) begin
			// Host keeps pre-dividers in the 1..3 range
			d = (i == 2 || i == 3) ? 8'($urandom_range(1, 3)) : 8'($urandom);
			wv[i] = d;
			wr(ofs[i], d);
			rd(ofs[i], d);
			`CHK("readback", (wv[i] & msk[i]) | (rst[i] & ~msk[i]), d)
		end
		`CHK("vtPix", wv[0][4:0], vtPix)
		`CHK("vtSys", wv[1][1:0], vtSys)
		`CHK("outPix", wv[6][4:0], outPix)
		`CHK("outSys", wv[7][1:0], outSys)
		`CHK("vtMpyHeld", RST_MPY, vtMpy)
		`CHK("outPreHeld", RST_PRE_DIV, outPre)
		frameRun = 1'b1;
		repeat (128) @(posedge core_clk);
		#1 frameRun = 1'b0;
		`CHK("vtPre", wv[2], vtPre)
		`CHK("vtMpy", {wv[4][2:0], wv[5]}, vtMpy)
		`CHK("outPre", wv[3], outPre)
		`CHK("outMpy", {wv[8][2:0], wv[9]}, outMpy)
		for (int i = 0; i < 6; i++) strobe_run(cs[i]);
		end_sim();
	end
endmodule : sensor_clock_and_strobe_setup_test
`default_nettype wire
